// ---- design/bpp_pkg.sv ----
package bpp_pkg;

   // ==========================================================================
   // Precedence codes and power conditions
   // ==========================================================================
   localparam logic [1:0] PREC_VENDOR = 2'h0;
   localparam logic [1:0] PREC_BG     = 2'h1;
   localparam logic [1:0] PREC_LP     = 2'h2;

   localparam int NUM_TMR = 5;
   localparam int NUM_BG  = 2;

   localparam int TMR_IDLE_A    = 0;
   localparam int TMR_IDLE_B    = 1;
   localparam int TMR_IDLE_C    = 2;
   localparam int TMR_STANDBY_Y = 3;
   localparam int TMR_STANDBY_Z = 4;

   localparam int BG_SCAN = 0;
   localparam int BG_DEV  = 1;

   // Power condition code: zero is active, otherwise timer index plus one.
   localparam logic [2:0] COND_ACTIVE = 3'h0;

   // Timer index per rank, rank 0 is the highest priority.
   localparam logic [NUM_TMR-1:0][2:0] TMR_RANK = {3'h0, 3'h1, 3'h2, 3'h3, 3'h4};

   // Conditions in which a background function can keep running.
   localparam logic [NUM_TMR-1:0] BG_OK_MASK = 5'h01;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam longint TICK_TIME_NS  = 100_000_000;
   localparam longint CLK_PERIOD_NS = 100;
   localparam int     TICK_CYCLES   = int'(TICK_TIME_NS / CLK_PERIOD_NS);
   localparam int     TMR_W         = 32;
   localparam int     PRE_W         = 32;

   typedef enum logic [2:0] {
      BPP_ST_AWAKE = 3'h1,
      BPP_ST_BG    = 3'h2,
      BPP_ST_LOW   = 3'h4
   } bpp_state_t;

endpackage

// ---- design/bpp_tmr_if.sv ----
`timescale 1ns/100ps
interface bpp_tmr_if
   import bpp_pkg::*;
   ();
   logic [NUM_TMR-1:0][TMR_W-1:0] init_val;
   logic [NUM_TMR-1:0]            enable;
   logic                          activity;
   logic [NUM_TMR-1:0]            expired;

   modport tmr (input init_val, input enable, input activity, output expired);
   modport ctl (output init_val, output enable, output activity, input expired);
endinterface

// ---- design/bpp_timer_bank.sv ----
`timescale 1ns/100ps
module bpp_timer_bank
   import bpp_pkg::*;
   #(
   parameter int TICKS = TICK_CYCLES
   ) (
   input  wire logic clk,
   input  wire logic rst_n,
   bpp_tmr_if.tmr    tif
   );

   // A zero prescale would compare against all ones and tick at most once every 2^32 cycles.
   if (TICKS < 1) begin : g_bad_ticks
      $error("bpp_timer_bank: TICKS must be at least one");
   end

   // ==========================================================================
   // Shared tenth-of-a-second prescaler
   // ==========================================================================
   logic [PRE_W-1:0] pre_q;
   logic             tick;

   assign tick = (pre_q == PRE_W'(TICKS - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= '0;
      end else if (tif.activity || tick) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + PRE_W'(1);
      end
   end

   // ==========================================================================
   // Inactivity timers
   // ==========================================================================
   genvar i;
   generate
      for (i = 0; i < NUM_TMR; i++) begin : g_tmr
         logic [TMR_W-1:0] cnt_q;
         logic             exp_q;

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               cnt_q <= '0;
               exp_q <= 1'b0;
            end else if (tif.activity) begin
               cnt_q <= '0;
               exp_q <= 1'b0;
            end else if (tick && !exp_q) begin
               cnt_q <= cnt_q + TMR_W'(1);
               exp_q <= ((cnt_q + TMR_W'(1)) >= tif.init_val[i]);
            end
         end

         assign tif.expired[i] = exp_q && tif.enable[i];
      end
   endgenerate

endmodule

// ---- design/bpp_top.sv ----
`timescale 1ns/100ps
module bpp_top
   import bpp_pkg::*;
   #(
   parameter int TICKS = TICK_CYCLES
   ) (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic [1:0]                    bg_power_precedence_code,
   input  wire logic [NUM_TMR-1:0]            timer_enable,
   input  wire logic [NUM_TMR-1:0][TMR_W-1:0] timer_init,
   input  wire logic [NUM_BG-1:0]             bg_enable,
   input  wire logic                          scan_timer_expired,
   input  wire logic                          device_event,
   input  wire logic [NUM_BG-1:0]             bg_done,
   input  wire logic                          host_cmd_pending,
   output logic      [2:0]                    power_cond,
   output logic      [NUM_BG-1:0]             bg_run,
   output logic      [NUM_BG-1:0]             bg_pending,
   output logic                               bg_suspended,
   output logic      [NUM_TMR-1:0]            timer_expired
   );

   // ==========================================================================
   // Reset release
   // ==========================================================================
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ==========================================================================
   // Inactivity timers
   // ==========================================================================
   bpp_tmr_if tif ();

   // Only host traffic counts as activity, so a timer can run out during
   // background work and the precedence policy then decides what happens.
   assign tif.init_val = timer_init;
   assign tif.enable   = timer_enable;
   assign tif.activity = host_cmd_pending;

   bpp_timer_bank #(
      .TICKS (TICKS)
   ) u_timers (
      .clk   (clk),
      .rst_n (rst_n_q),
      .tif   (tif)
   );

   // ==========================================================================
   // Helper functions
   // ==========================================================================
   // fixed priority pick
   function automatic logic [2:0] pick_cond(input logic [NUM_TMR-1:0] exp);
      logic [2:0] res;
      res = COND_ACTIVE;
      for (int r = NUM_TMR - 1; r >= 0; r--) begin
         if (exp[TMR_RANK[r]]) begin
            res = TMR_RANK[r] + 3'h1;
         end
      end
      return res;
   endfunction

   function automatic logic [NUM_BG-1:0] pick_bg(input logic [NUM_BG-1:0] pend);
      logic [NUM_BG-1:0] res;
      res = '0;
      for (int b = NUM_BG - 1; b >= 0; b--) begin
         if (pend[b]) begin
            res = '0;
            res[b] = 1'b1;
         end
      end
      return res;
   endfunction

   // Condition code zero is active, so it never maps onto the mask.
   function automatic logic cond_allows_bg(input logic [2:0] cond);
      logic ok;
      ok = 1'b0;
      for (int t = 0; t < NUM_TMR; t++) begin
         if (cond == 3'(t + 1)) begin
            ok = BG_OK_MASK[t];
         end
      end
      return ok;
   endfunction

   // A timer missing from the rank table could expire and never be chosen.
   function automatic logic rank_is_perm();
      logic [NUM_TMR-1:0] seen;
      seen = '0;
      for (int r = 0; r < NUM_TMR; r++) begin
         if (int'(TMR_RANK[r]) < NUM_TMR) begin
            seen[TMR_RANK[r]] = 1'b1;
         end
      end
      return &seen;
   endfunction

   // ==========================================================================
   // Elaboration checks
   // ==========================================================================
   // The condition code is three bits wide and only two initiating inputs exist.
   if (TICKS < 1) begin : g_bad_ticks
      $error("bpp_top: TICKS must be at least one");
   end
   if (NUM_TMR > 7) begin : g_bad_tmr
      $error("bpp_top: condition code cannot name that many timers");
   end
   if (NUM_BG != 2) begin : g_bad_bg
      $error("bpp_top: exactly two background functions are wired");
   end
   if (!rank_is_perm()) begin : g_bad_rank
      $error("bpp_top: timer rank table is not a permutation");
   end

   // ==========================================================================
   // Policy decode
   // ==========================================================================
   logic               lp_first;
   logic [NUM_TMR-1:0] exp;
   logic               any_exp;
   logic [2:0]         target;
   logic               target_bg_ok;

   // Only the low-power code is decoded, so the reserved code also falls
   // through to background-first rather than to an undefined policy.
   // code zero acts as background-first
   assign lp_first     = (bg_power_precedence_code == PREC_LP);
   assign exp          = tif.expired;
   assign any_exp      = |exp;
   assign target       = pick_cond(exp);
   assign target_bg_ok = cond_allows_bg(target);

   // ==========================================================================
   // Pending background functions
   // ==========================================================================
   logic [NUM_BG-1:0] pend_q;
   logic [NUM_BG-1:0] run_q;
   logic [NUM_BG-1:0] init_ev;
   logic [NUM_BG-1:0] finish;

   assign init_ev[BG_SCAN] = scan_timer_expired && bg_enable[BG_SCAN];
   assign init_ev[BG_DEV]  = device_event && bg_enable[BG_DEV];
   assign finish           = bg_done & run_q;

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q & ~finish) | init_ev;
      end
   end

   // Work still owed once this cycle's completions are taken off.
   logic [NUM_BG-1:0] pend_left;
   assign pend_left = pend_q & ~finish;

   // ==========================================================================
   // Power and background state machine
   // ==========================================================================
   bpp_state_t        st_q;
   bpp_state_t        st_d;
   logic [2:0]        cond_q;
   logic [2:0]        cond_d;
   logic [NUM_BG-1:0] run_d;
   logic              susp_q;
   logic              susp_d;

   always_comb begin
      st_d   = st_q;
      cond_d = cond_q;
      run_d  = run_q;
      susp_d = susp_q;
      case (st_q)
         BPP_ST_AWAKE: begin
            cond_d = COND_ACTIVE;
            if (!host_cmd_pending && |pend_q) begin
               st_d   = BPP_ST_BG;
               run_d  = pick_bg(pend_q);
               susp_d = 1'b0;
            end else if (!host_cmd_pending && any_exp) begin
               st_d   = BPP_ST_LOW;
               cond_d = target;
            end
         end
         BPP_ST_BG: begin
            if (host_cmd_pending) begin
               st_d   = BPP_ST_AWAKE;
               run_d  = '0;
               susp_d = 1'b1;
            end else if (lp_first && any_exp && !target_bg_ok) begin
               st_d   = BPP_ST_LOW;
               cond_d = target;
               run_d  = '0;
               susp_d = |pend_left;
            end else if (|pend_left) begin
               run_d = (|(run_q & ~finish)) ? run_q : pick_bg(pend_left);
            end else if (any_exp) begin
               st_d   = BPP_ST_LOW;
               cond_d = target;
               run_d  = '0;
            end else begin
               st_d  = BPP_ST_AWAKE;
               run_d = '0;
            end
         end
         BPP_ST_LOW: begin
            if (host_cmd_pending) begin
               st_d   = BPP_ST_AWAKE;
               cond_d = COND_ACTIVE;
            end else if (!lp_first && |pend_q) begin
               // wake for scan; wake for event
               st_d   = BPP_ST_BG;
               cond_d = COND_ACTIVE;
               run_d  = pick_bg(pend_q);
               susp_d = 1'b0;
            end else if (any_exp) begin
               cond_d = target;
            end
         end
         default: begin
            st_d   = BPP_ST_AWAKE;
            cond_d = COND_ACTIVE;
            run_d  = '0;
            susp_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q <= BPP_ST_AWAKE;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cond_q <= COND_ACTIVE;
      end else begin
         cond_q <= cond_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         run_q <= '0;
      end else begin
         run_q <= run_d;
      end
   end

   // The suspended flag shows that work is parked, not lost.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         susp_q <= 1'b0;
      end else begin
         susp_q <= susp_d;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   assign power_cond    = cond_q;
   assign bg_run        = run_q;
   assign bg_pending    = pend_q;
   assign bg_suspended  = susp_q;
   assign timer_expired = exp;

endmodule

// ---- testbench/bpp_host_model.sv ----
`timescale 1ns/100ps
module bpp_host_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       start,
   input  wire logic [7:0] len,
   output logic            host_cmd_pending
   );
   logic [7:0] left_q;

   // The request stands as a level for the whole command, since the unit must see it
   // outstanding until it is served, not as a single strobe.
   always_ff @(negedge clk) begin
      if (!rst_n) begin
         left_q <= 8'h0;
      end else if (start) begin
         left_q <= len;
      end else if (left_q != 8'h0) begin
         left_q <= left_q - 8'h1;
      end
   end

   assign host_cmd_pending = left_q != 8'h0;
endmodule

// ---- testbench/bpp_checker.sv ----
`timescale 1ns/100ps
module bpp_checker
   import bpp_pkg::*;
   (
   input wire logic               clk,
   input wire logic               reset_n,
   input wire logic [1:0]         bg_power_precedence_code,
   input wire logic [NUM_TMR-1:0] timer_enable,
   input wire logic [NUM_BG-1:0]  bg_enable,
   input wire logic               scan_timer_expired,
   input wire logic               device_event,
   input wire logic [NUM_BG-1:0]  bg_done,
   input wire logic               host_cmd_pending,
   input wire logic [2:0]         power_cond,
   input wire logic [NUM_BG-1:0]  bg_run,
   input wire logic [NUM_BG-1:0]  bg_pending,
   input wire logic               bg_suspended,
   input wire logic [NUM_TMR-1:0] timer_expired
   );
   logic              lp;
   logic [2:0]        best;
   logic [NUM_BG-1:0] init;

   assign lp   = bg_power_precedence_code == PREC_LP;
   assign init = bg_enable & {device_event, scan_timer_expired};

   // Higher timer index outranks lower, so the last expired one wins.
   always_comb begin
      best = COND_ACTIVE;
      for (int i = 0; i < NUM_TMR; i++) begin
         if (timer_expired[i]) begin
            best = 3'(i + 1);
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_asleep;
      lp && power_cond != COND_ACTIVE && !host_cmd_pending;
   endsequence

   a_pend_set:
   assert property (init != 0 |=> (bg_pending & $past(init)) == $past(init))
      else $error("initiated function not pending");
   a_host_suspends:
   assert property (bg_run != 0 && host_cmd_pending |=> bg_run == 0 && bg_suspended)
      else $error("host command did not suspend work");
   a_bg_wakes:
   assert property (!lp && bg_pending != 0 && bg_run == 0 && !host_cmd_pending
      |=> ##[0:1] bg_run != 0 && power_cond == COND_ACTIVE)
      else $error("pending work did not start");
   a_bg_active:
   assert property (!lp && bg_run != 0 |-> power_cond == COND_ACTIVE)
      else $error("low power entered during work");
   a_done_enter:
   assert property (!lp && bg_pending == bg_run && (bg_done & bg_run) != 0 && init == 0
      && !host_cmd_pending |=> bg_pending == 0 && power_cond == $past(best))
      else $error("wrong condition after work");
   a_lp_no_wake:
   assert property (s_asleep ##1 s_asleep |=> power_cond != COND_ACTIVE)
      else $error("woke for background work");
   a_lp_run_awake:
   assert property (lp && $rose(bg_run != 0)
      |-> power_cond == COND_ACTIVE && !$past(host_cmd_pending))
      else $error("work started while asleep or busy");
   a_lp_deep_stop:
   assert property (lp && bg_run != 0 && (timer_expired & ~BG_OK_MASK) != 0
      && !host_cmd_pending |=> ##[0:1] bg_run == 0 && power_cond != COND_ACTIVE)
      else $error("work not suspended for deep timer");
   a_expiry_gated:
   assert property ((timer_expired & ~timer_enable) == 0)
      else $error("disabled timer flagged");
   a_host_clears:
   assert property (host_cmd_pending |=> timer_expired == 0)
      else $error("host activity did not clear timers");
endmodule

bind bpp_top bpp_checker u_chk (.*);

// ---- testbench/bpp_top_tb.sv ----
`timescale 1ns/100ps
module bpp_top_tb
   import bpp_pkg::*;
   ;
   logic                          clk, reset_n, scan, dev, host_req, host, susp;
   logic [1:0]                    code;
   logic [NUM_TMR-1:0]            t_en, expd;
   logic [NUM_TMR-1:0][TMR_W-1:0] t_init;
   logic [NUM_BG-1:0]             bg_en, done, run, pend;
   logic [7:0]                    host_len;
   logic [2:0]                    cond;
   int                            num_errors, tests_run, cycles;

   bpp_top #(.TICKS(4)) DUT (.clk(clk), .reset_n(reset_n), .bg_power_precedence_code(code),
      .timer_enable(t_en), .timer_init(t_init), .bg_enable(bg_en), .scan_timer_expired(scan),
      .device_event(dev), .bg_done(done), .host_cmd_pending(host), .power_cond(cond),
      .bg_run(run), .bg_pending(pend), .bg_suspended(susp), .timer_expired(expd));
   bpp_host_model u_host (.clk(clk), .rst_n(reset_n), .start(host_req), .len(host_len),
      .host_cmd_pending(host));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("Checks %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wait_on(input logic w, input logic [2:0] v);
      int n;
      n = 0;
      while ((w ? {1'b0, run} : cond) !== v && n < 80) begin
         @(negedge clk);
         n++;
      end
      check(w ? "run" : "cond", w ? {1'b0, run} : cond, v);
   endtask

   task automatic do_reset(input logic [1:0] c);
      @(negedge clk);
      reset_n <= 1'b0;
      code    <= c;
      repeat (16) @(negedge clk);
      reset_n <= 1'b1;
      repeat (3) @(negedge clk);
   endtask

   task automatic pulse(input logic s, input logic d, input logic [1:0] f);
      @(negedge clk);
      scan <= s;
      dev  <= d;
      done <= f;
      @(negedge clk);
      scan <= 1'b0;
      dev  <= 1'b0;
      done <= 2'b00;
   endtask

   task automatic host_cmd(input logic [7:0] n);
      @(negedge clk);
      host_req <= 1'b1;
      host_len <= n;
      @(negedge clk);
      host_req <= 1'b0;
   endtask

   // Both functions are started in the same cycle so the unit has to queue one of them.
   task automatic test_bg_first(input logic [1:0] c);
      do_reset(c);
      wait_on(1'b0, 3'h4);
      check("expd", expd, 5'h09);
      pulse(1'b1, 1'b1, 2'b00);
      repeat (2) @(negedge clk);
      check("run", run, 2'b01);
      check("cond", cond, COND_ACTIVE);
      check("pend", pend, 2'b11);
      pulse(1'b0, 1'b0, 2'b01);
      wait_on(1'b1, 3'h2);
      check("cond", cond, COND_ACTIVE);
      pulse(1'b0, 1'b0, 2'b10);
      @(negedge clk);
      check("pend", pend, 2'b00);
      check("cond", cond, 3'h4);
   endtask

   task automatic test_host();
      do_reset(PREC_BG);
      pulse(1'b1, 1'b0, 2'b00);
      repeat (2) @(negedge clk);
      check("run", run, 2'b01);
      host_cmd(8'h3);
      repeat (2) @(negedge clk);
      check("run", run, 2'b00);
      check("susp", susp, 1'b1);
      wait_on(1'b1, 3'h1);
      check("cond", cond, COND_ACTIVE);
      pulse(1'b0, 1'b0, 2'b01);
      bg_en <= 2'h1;
      pulse(1'b0, 1'b1, 2'h0);
      @(negedge clk);
      check("pend", pend, 2'h0);
      bg_en <= 2'h3;
   endtask

   task automatic test_lp();
      do_reset(PREC_LP);
      repeat (5) @(negedge clk);
      check("cond", cond, COND_ACTIVE);
      check("expd", expd, 5'h00);
      wait_on(1'b0, 3'h1);
      pulse(1'b0, 1'b1, 2'b00);
      repeat (3) @(negedge clk);
      check("run", run, 2'b00);
      check("pend", pend, 2'b10);
      check("cond", cond, 3'h1);
      host_cmd(8'h2);
      wait_on(1'b1, 3'h2);
      check("cond", cond, COND_ACTIVE);
      wait_on(1'b0, 3'h4);
      check("run", run, 2'b00);
      check("susp", susp, 1'b1);
   endtask

   initial begin
      reset_n  = 1'b0;
      code     = PREC_BG;
      scan     = 1'b0;
      dev      = 1'b0;
      done     = 2'b00;
      host_req = 1'b0;
      host_len = 8'h0;
      bg_en    = 2'b11;
      t_en     = 5'h09;
      t_init   = '0;
      t_init[TMR_IDLE_A]    = 32'h2;
      t_init[TMR_STANDBY_Y] = 32'h8;
      num_errors = 0;
      tests_run  = 0;
      cycles     = 0;
      test_bg_first(PREC_VENDOR);
      test_bg_first(PREC_BG);
      test_bg_first(2'h3);
      test_host();
      test_lp();
      complete_run();
   end
endmodule
